// file: nvc_pkg.sv
// package with register map, field layout, timing and shared types for the nvm controller
// Functional notes
// - region_select picks eeprom/config space or flash
// - latch_only go copies data into write latch
// - latch_only clear go performs real write
// - erase_select go erases 32-word row to ones
// - fault_flag on reset, broken unlock, protected write
// - hardware clears fault_flag only on core reset
// - software writing one sets fault_flag
// - fault_flag reads undefined during eeprom write
// - address bit 15 undefined while busy
// - program_enable low inhibits flash program/erase
// - eeprom go erases then programs one location
// - program_go set only right after unlock
// - operations self-timed, hardware clears program_go
// - writing zero to program_go does nothing
// - read_start reads within one cycle, self-clears
// - software can only set read_start
// - eeprom read updates only data low byte
// - address register 15 bits, two bytes
// - data register 14 bits, two bytes
// - data register kept across non-power resets
// - unlock is 0x55 then 0xAA then go
// - invalid config-space read clears data register
// - row write resets latches; protected aborts with fault
package nvc_pkg;

  // ----------------------------------------------------------------
  // register word addresses (printed offsets are used as word indices)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_ADDRESS = 12'h081a;  // mem_address index
  localparam logic [11:0] IDX_DATA    = 12'h081c;  // mem_data index
  localparam logic [11:0] IDX_CONTROL = 12'h081e;  // mem_control index
  localparam logic [11:0] IDX_UNLOCK  = 12'h081f;  // unlock_register index
  localparam int          AW          = 14;        // avalon word address width

  // ----------------------------------------------------------------
  // mem_control field positions
  // ----------------------------------------------------------------
  localparam int B_READ   = 0;  // read_start
  localparam int B_GO     = 1;  // program_go
  localparam int B_PROGRAM_ENABLE   = 2;  // program_enable
  localparam int B_FAULT  = 3;  // fault_flag
  localparam int B_ERASE  = 4;  // erase_select
  localparam int B_LATCH  = 5;  // latch_only
  localparam int B_REGION = 6;  // region_select

  // ----------------------------------------------------------------
  // unlock pattern, erased values, sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'haa;
  localparam logic [13:0] LATCH_RESET = 14'h03ff;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam int          ROW_WORDS   = 32;
  localparam int          ROW_BITS    = 5;

  // ----------------------------------------------------------------
  // region windows inside the upper space (region_select set)
  // ----------------------------------------------------------------
  localparam logic [14:0] UID_LO  = 15'h0000;
  localparam logic [14:0] UID_HI  = 15'h0003;
  localparam logic [14:0] DID_LO  = 15'h0005;
  localparam logic [14:0] DID_HI  = 15'h0006;
  localparam logic [14:0] CFG_LO  = 15'h0007;
  localparam logic [14:0] CFG_HI  = 15'h000b;
  localparam logic [14:0] INFO_LO = 15'h0100;
  localparam logic [14:0] INFO_HI = 15'h02ff;
  localparam logic [14:0] EE_LO   = 15'h7000;
  localparam logic [14:0] EE_HI   = 15'h70ff;

  // ----------------------------------------------------------------
  // timing, in microseconds and cycles of a 20 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 20;
  localparam int T_WRITE_US    = 2000;  // self-timed program/erase
  localparam int WRITE_CYCLES  = T_WRITE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // no operation running
    ST_BUSY  = 2'b01,  // self-timed operation counting
    ST_DONE  = 2'b10   // commit result and clear program_go
  } nvc_state_t;

  typedef struct packed {
    logic region;  // region_select
    logic latch;   // latch_only
    logic erase;   // erase_select
    logic fault;   // fault_flag
    logic program_enable;    // program_enable
    logic go;      // program_go
    logic rd;      // read_start
  } nvc_ctrl_t;

endpackage : nvc_pkg

// file: nvc_top.sv
// nvm control register block with avalon-mm slave, unlock, self-timed operations
`timescale 1ns/1ps
`default_nettype none
module nvc_top #(
  parameter int WRITE_CYCLES = nvc_pkg::WRITE_CYCLES,  // self-timed length, shorten in simulation
  parameter int EE_WORDS     = 256,                    // eeprom bytes
  parameter int FLASH_WORDS  = 1024                    // modelled flash words
) (
  input  wire logic                   ref_clk_i,            // 20 MHz clock
  input  wire logic                   nrst_i,               // async reset, active low
  input  wire logic                   por_n_i,              // power-on/brown-out reset, active low
  input  wire logic                   ce_i,                 // clock enable, freezes all state
  input  wire logic [nvc_pkg::AW-1:0] avs_address_i,        // word address
  input  wire logic                   avs_read_i,           // read request
  input  wire logic                   avs_write_i,          // write request
  input  wire logic [31:0]            avs_writedata_i,      // write data
  input  wire logic [3:0]             avs_byteenable_i,     // byte lanes
  input  wire logic                   wp_i,                 // addressed location is write-protected
  output logic      [31:0]            avs_readdata_o,       // read data
  output logic                        avs_waitrequest_o,    // stall
  output logic                        busy_o                // program/erase running
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic       req     = avs_read_i | avs_write_i;
  wire logic       hit_adr = (avs_address_i == nvc_pkg::IDX_ADDRESS);
  wire logic       hit_dat = (avs_address_i == nvc_pkg::IDX_DATA);
  wire logic       hit_con = (avs_address_i == nvc_pkg::IDX_CONTROL);
  wire logic       hit_unl = (avs_address_i == nvc_pkg::IDX_UNLOCK);
  wire logic [7:0] wb0     = avs_writedata_i[7:0];
  wire logic [7:0] wb1     = avs_writedata_i[15:8];

  // ack register: one wait cycle, then accept at the edge where waitrequest is low
  logic ack_reg;
  logic wait_reg;                                      // registered waitrequest, high when idle or stalling
  wire logic take = req & ack_reg;                     // request completes this edge
  wire logic wr_t = take & avs_write_i;
  wire logic rd_t = take & avs_read_i;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [14:0]                 adr_reg;                // mem_address
  logic [13:0]                 dat_reg;                // mem_data, no async reset
  nvc_pkg::nvc_ctrl_t          ctl_reg;                // mem_control
  logic [1:0]                  key_reg;                // unlock progress
  nvc_pkg::nvc_state_t         st_reg;                 // operation state
  logic [31:0]                 cnt_reg;                // self-timer
  logic [1:0]                  op_reg;                 // 0 ee, 1 erase, 2 row write
  logic                        init_reg;               // fault capture after reset pending
  logic                        was_busy_reg;           // kept across reset for fault capture
  logic [13:0]                 latch_mem [nvc_pkg::ROW_WORDS];  // row write latches
  logic [13:0]                 flash_mem [FLASH_WORDS];          // program flash array
  logic [7:0]                  ee_mem    [EE_WORDS];             // eeprom array
  logic [31:0]                 rdata_reg;

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [14:0] a, input logic [14:0] lo, input logic [14:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  wire logic is_ee   = ctl_reg.region & in_rng(adr_reg, nvc_pkg::EE_LO, nvc_pkg::EE_HI);
  wire logic cfg_rd  = in_rng(adr_reg, nvc_pkg::UID_LO, nvc_pkg::UID_HI)
                     | in_rng(adr_reg, nvc_pkg::DID_LO, nvc_pkg::CFG_HI)
                     | in_rng(adr_reg, nvc_pkg::INFO_LO, nvc_pkg::INFO_HI);
  wire logic busy    = (st_reg != nvc_pkg::ST_IDLE);
  wire logic [ 4:0] row_ix = adr_reg[nvc_pkg::ROW_BITS-1:0];
  wire logic [14:0] row_base = {adr_reg[14:nvc_pkg::ROW_BITS], 5'h00};

  // ----------------------------------------------------------------
  // control write decode
  // ----------------------------------------------------------------
  wire logic con_wr  = wr_t & hit_con & avs_byteenable_i[0];
  wire logic unl_wr  = wr_t & hit_unl & avs_byteenable_i[0];
  wire logic go_req  = con_wr & wb0[nvc_pkg::B_GO] & ~ctl_reg.go;
  wire logic unlocked = (key_reg == 2'd2);
  wire logic go_ok   = go_req & unlocked & ~busy;
  wire logic key_bad = (key_reg != 2'd0) & wr_t & ~unl_wr & ~go_req;
  wire logic go_bad  = go_req & ~unlocked;
  wire logic flash_inhibit = ~ctl_reg.region & ~ctl_reg.program_enable;
  wire logic latch_op = ~ctl_reg.region & ~ctl_reg.erase & ctl_reg.latch;
  wire logic prot_hit = go_ok & wp_i & ~latch_op;
  wire logic launch = go_ok & ~prot_hit & ~flash_inhibit & ~latch_op;
  wire logic rd_go  = con_wr & wb0[nvc_pkg::B_READ] & ~busy;

  // ----------------------------------------------------------------
  // bus handshake: waitrequest high until the acknowledge cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg  <= 1'b0;
      wait_reg <= 1'b1;
    end else if (ce_i) begin
      ack_reg  <= req & ~ack_reg;
      // kept as the inverse of the next ack so the pin comes straight from a flop
      wait_reg <= ~(req & ~ack_reg);
    end
  end

  // ----------------------------------------------------------------
  // unlock sequencer: any other write in between breaks it
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_reg <= 2'd0;
    end else if (ce_i) begin
      if (unl_wr && wb0 == nvc_pkg::KEY_FIRST) begin
        key_reg <= 2'd1;
      end else if (unl_wr && wb0 == nvc_pkg::KEY_SECOND && key_reg == 2'd1) begin
        key_reg <= 2'd2;
      end else if (wr_t) begin
        key_reg <= 2'd0;                                                       // consumed or broken
      end
    end
  end

  // ----------------------------------------------------------------
  // address register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adr_reg <= 15'h0000;
    end else if (ce_i && wr_t && hit_adr) begin
      if (avs_byteenable_i[0]) adr_reg[7:0]  <= wb0;
      if (avs_byteenable_i[1]) adr_reg[14:8] <= wb1[6:0];
    end
  end

  // ----------------------------------------------------------------
  // control register and operation state machine
  // fault_flag is cleared by reset: a running operation sets it again on restart
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_reg  <= '0;
      st_reg   <= nvc_pkg::ST_IDLE;
      cnt_reg  <= 32'h0000_0000;
      op_reg   <= 2'b00;
      init_reg <= 1'b1;
    end else if (ce_i) begin
      init_reg <= 1'b0;
      ctl_reg.rd <= rd_go;                                                     // one cycle
      if (con_wr) begin
        ctl_reg.region <= wb0[nvc_pkg::B_REGION];
        ctl_reg.latch  <= wb0[nvc_pkg::B_LATCH];
        ctl_reg.erase  <= wb0[nvc_pkg::B_ERASE];
        ctl_reg.program_enable   <= wb0[nvc_pkg::B_PROGRAM_ENABLE];
      end
      // fault: software may write either value, hardware only sets; set wins
      if (init_reg && was_busy_reg) begin
        ctl_reg.fault <= 1'b1;
      end else if (key_bad || go_bad || prot_hit) begin
        ctl_reg.fault <= 1'b1;
      end else if (con_wr) begin
        ctl_reg.fault <= wb0[nvc_pkg::B_FAULT];
      end
      unique case (st_reg)
        nvc_pkg::ST_IDLE: begin
          if (launch) begin
            ctl_reg.go <= 1'b1;
            st_reg     <= nvc_pkg::ST_BUSY;
            cnt_reg    <= 32'(WRITE_CYCLES - 1);
            op_reg     <= is_ee ? 2'd0 : (ctl_reg.erase ? 2'd1 : 2'd2);
          end
        end
        nvc_pkg::ST_BUSY: begin
          // a zero written to program_go is not looked at here
          if (cnt_reg == 32'h0000_0000) st_reg <= nvc_pkg::ST_DONE;
          else cnt_reg <= cnt_reg - 32'h0000_0001;
        end
        nvc_pkg::ST_DONE: begin
          ctl_reg.go <= 1'b0;
          st_reg     <= nvc_pkg::ST_IDLE;
        end
        default: st_reg <= nvc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power-domain state: only the power-on reset clears these
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      was_busy_reg <= 1'b0;
    end else if (ce_i) begin
      // hold the capture while the core reset is low, so the restart still sees it
      if (nrst_i) was_busy_reg <= busy;
    end
  end

  // ----------------------------------------------------------------
  // data register and arrays: no reset, unknown until loaded
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (wr_t && hit_dat) begin
        if (avs_byteenable_i[0]) dat_reg[7:0]  <= wb0;
        if (avs_byteenable_i[1]) dat_reg[13:8] <= wb1[5:0];
      end else if (ctl_reg.rd) begin
        if (is_ee) dat_reg[7:0] <= ee_mem[adr_reg[7:0]];
        else if (!ctl_reg.region) dat_reg <= flash_mem[adr_reg[9:0]];
        else if (!cfg_rd) dat_reg <= 14'h0000;
      end
      if (go_ok && latch_op) latch_mem[row_ix] <= dat_reg;
      if (st_reg == nvc_pkg::ST_DONE) begin
        for (int i = 0; i < nvc_pkg::ROW_WORDS; i++) begin
          if (op_reg == 2'd1) flash_mem[10'(row_base) + 10'(i)] <= nvc_pkg::ERASED_WORD;
          if (op_reg == 2'd2) begin
            flash_mem[10'(row_base) + 10'(i)] <= latch_mem[i];
            latch_mem[i] <= nvc_pkg::LATCH_RESET;
          end
        end
        if (op_reg == 2'd0) ee_mem[adr_reg[7:0]] <= dat_reg[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux; bit 15 reads busy and fault reads zero while undefined
  // ----------------------------------------------------------------
  wire logic [7:0] con_rd = {1'b0, ctl_reg.region, ctl_reg.latch, ctl_reg.erase,
                             ctl_reg.fault & ~(busy & op_reg == 2'd0),
                             ctl_reg.program_enable, ctl_reg.go, ctl_reg.rd};
  wire logic [31:0] rd_mux = hit_adr ? {16'h0000, busy, adr_reg} :
                             hit_dat ? {18'h0_0000, dat_reg} :
                             hit_con ? {24'h00_0000, con_rd} : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_reg <= (avs_read_i && !ack_reg) ? rd_mux : rdata_reg;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign busy_o            = ctl_reg.go;

endmodule : nvc_top
`default_nettype wire

// file: nvc_chk_sva.sv
// concurrent checks on the avalon handshake, busy timing and read-back shape of the nvm controller
`timescale 1ns/1ps
`default_nettype none
module nvc_chk #(
  parameter int WRITE_CYCLES = 8  // self-timed length, same as the bound instance
) (
  input wire logic                   ref_clk_i,          // sampling clock
  input wire logic                   nrst_i,             // async reset, active low
  input wire logic [nvc_pkg::AW-1:0] avs_address_i,      // word address
  input wire logic                   avs_read_i,         // read request
  input wire logic                   avs_write_i,        // write request
  input wire logic [31:0]            avs_writedata_i,    // write data
  input wire logic                   wp_i,               // protected location
  input wire logic [31:0]            avs_readdata_o,     // read data
  input wire logic                   avs_waitrequest_o,  // stall
  input wire logic                   busy_o              // program/erase running
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  localparam logic [13:0] A_ADR = 14'(nvc_pkg::IDX_ADDRESS);  // mem_address
  localparam logic [13:0] A_DAT = 14'(nvc_pkg::IDX_DATA);     // mem_data
  localparam logic [13:0] A_CTL = 14'(nvc_pkg::IDX_CONTROL);  // mem_control
  localparam logic [13:0] A_UNL = 14'(nvc_pkg::IDX_UNLOCK);   // unlock_register
  wire take_rd = avs_read_i && !avs_waitrequest_o;            // read completes this edge
  wire take_wr = avs_write_i && !avs_waitrequest_o;           // write completes this edge
  wire mapped  = (avs_address_i == A_ADR) || (avs_address_i == A_DAT) ||
                 (avs_address_i == A_CTL) || (avs_address_i == A_UNL);
  wire go_req  = take_wr && (avs_address_i == A_CTL) && avs_writedata_i[nvc_pkg::B_GO];
  logic [15:0] busy_cnt;  // length of the current busy stretch

  // counter of busy cycles; a repetition cannot take the parameter as its count
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_o ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_ack_has_req: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
    else $error("acknowledge without a request");
  a_ack_latency: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  a_busy_length: assert property ($fell(busy_o) |-> busy_cnt == 16'(WRITE_CYCLES + 1))
    else $error("self-timed operation has the wrong length");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(go_req))
    else $error("operation started without a program_go write");
  a_wp_blocks: assert property (go_req && wp_i && !busy_o |=> !busy_o)
    else $error("operation started on a protected location");
  a_unmapped_zero: assert property (take_rd && !mapped |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_data_width: assert property (take_rd && avs_address_i == A_DAT |-> avs_readdata_o[31:14] == 18'h0_0000)
    else $error("data register wider than fourteen bits");
  a_addr_width: assert property (take_rd && avs_address_i == A_ADR |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("address register upper half not zero");
  a_ctl_width: assert property (take_rd && avs_address_i == A_CTL |-> avs_readdata_o[31:7] == 25'h000_0000)
    else $error("control register unused bits not zero");
endmodule : nvc_chk
`default_nettype wire

// file: tb.sv
// self-checking bench for the nvm controller driven over avalon-mm
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam int          WRITE_CYCLES = 8;  // short self-timed length for simulation
  localparam logic [13:0] A_ADR = 14'(nvc_pkg::IDX_ADDRESS);
  localparam logic [13:0] A_DAT = 14'(nvc_pkg::IDX_DATA);
  localparam logic [13:0] A_CTL = 14'(nvc_pkg::IDX_CONTROL);
  localparam logic [13:0] A_UNL = 14'(nvc_pkg::IDX_UNLOCK);
  logic        ref_clk_i = 1'b0, nrst_i = 1'b0, por_n_i = 1'b0, ce_i = 1'b1;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, wp_i = 1'b0;
  logic [13:0] avs_address_i = 14'h0000;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'h3;  // both byte lanes of each register
  logic [31:0] avs_readdata_o, rdata;
  logic        avs_waitrequest_o, busy_o;
  int          err_count = 0, checks = 0, n;

  always #25 ref_clk_i = ~ref_clk_i;  // 20 MHz

  nvc_top #(.WRITE_CYCLES(WRITE_CYCLES)) dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .por_n_i(por_n_i),
    .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .wp_i(wp_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

  // ----------------------------------------------------------------
  // bus tasks: hold the request until waitrequest is sampled low
  // ----------------------------------------------------------------
  task automatic bus(input logic wr_en, input logic [13:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr_en;
    avs_read_i      <= !wr_en;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    if (avs_waitrequest_o !== 1'b0) err_count++;  // slave never answered
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge ref_clk_i);  // idle cycle so the next request never shares a time step
  endtask : bus
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [13:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rdata & m)
  endtask : rdc
  // unlock pattern followed at once by the control write
  task automatic go(input logic [31:0] c);
    wr(A_CTL, c & 32'hffff_fffd);  // mode bits settle before the unlock
    wr(A_UNL, 32'h0000_0055);
    wr(A_UNL, 32'h0000_00aa);
    wr(A_CTL, c);
  endtask : go
  // count busy cycles, bounded so a stuck operation cannot hang the run
  task automatic idle();
    n = 0;
    while (busy_o === 1'b1 && n < 1000) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask : idle
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i  <= 1'b1;
    por_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rdc(A_ADR, 32'hffff_ffff, 32'h0000_0000, "adr_rst");
    rdc(A_CTL, 32'h0000_00f7, 32'h0000_0000, "ctl_rst");
    wr(A_ADR, 32'h0000_ffff);
    rdc(A_ADR, 32'hffff_ffff, 32'h0000_7fff, "adr_bits");
    wr(A_DAT, 32'h0000_ffff);
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_3fff, "dat_bits");
    rdc(14'h0819, 32'hffff_ffff, 32'h0000_0000, "unmapped");
    // flash: erase the row, read it, then latch load and row write
    wr(A_ADR, 32'h0000_0040);
    go(32'h0000_0016);
    idle();
    `CHK("erase_len", WRITE_CYCLES + 1, n)
    wr(A_CTL, 32'h0000_0001);
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_3fff, "erased");
    wr(A_DAT, 32'h0000_1abc);
    go(32'h0000_0026);
    `CHK("latch_busy", 1'b0, busy_o)
    go(32'h0000_0006);
    idle();
    `CHK("write_len", WRITE_CYCLES + 1, n)
    wr(A_CTL, 32'h0000_0001);
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_1abc, "written");
    // program_enable low, broken unlock, sticky fault, protected location
    wr(A_CTL, 32'h0000_0000);
    go(32'h0000_0002);
    `CHK("inhibit", 1'b0, busy_o)
    wr(A_CTL, 32'h0000_0004);
    wr(A_UNL, 32'h0000_0055);
    wr(A_DAT, 32'h0000_0000);
    rdc(A_CTL, 32'h0000_0008, 32'h0000_0008, "unlock_break");
    wr(A_UNL, 32'h0000_00aa);
    wr(A_CTL, 32'h0000_000e);
    `CHK("no_start", 1'b0, busy_o)
    repeat (20) @(posedge ref_clk_i);
    rdc(A_CTL, 32'h0000_0008, 32'h0000_0008, "fault_held");
    wr(A_CTL, 32'h0000_0004);
    rdc(A_CTL, 32'h0000_0008, 32'h0000_0000, "fault_clr");
    wr(A_CTL, 32'h0000_000c);
    rdc(A_CTL, 32'h0000_0008, 32'h0000_0008, "fault_sw");
    wr(A_CTL, 32'h0000_0004);
    wp_i <= 1'b1;
    go(32'h0000_0006);
    `CHK("wp_busy", 1'b0, busy_o)
    rdc(A_CTL, 32'h0000_000a, 32'h0000_0008, "fault_wp");
    wp_i <= 1'b0;
    // clearing program_go and starting a read while busy change nothing
    wr(A_CTL, 32'h0000_0004);
    wr(A_DAT, 32'h0000_0123);
    go(32'h0000_0006);
    wr(A_CTL, 32'h0000_0005);
    `CHK("go_kept", 1'b1, busy_o)
    rdc(A_ADR, 32'h0000_8000, 32'h0000_8000, "adr_busy");
    idle();
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_0123, "rd_ignored");
    // eeprom byte program and low-byte read, then a gap in config space
    wr(A_ADR, 32'h0000_7000);
    wr(A_DAT, 32'h0000_1234);
    go(32'h0000_0046);
    idle();
    `CHK("ee_len", WRITE_CYCLES + 1, n)
    wr(A_DAT, 32'h0000_3f00);
    wr(A_CTL, 32'h0000_0041);
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_3f34, "ee_low");
    wr(A_ADR, 32'h0000_0004);
    wr(A_CTL, 32'h0000_0041);
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_0000, "cfg_gap");
    // reset in mid-write: fault raised, data register kept
    wr(A_ADR, 32'h0000_0040);
    wr(A_DAT, 32'h0000_2d2d);
    go(32'h0000_0006);
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rdc(A_CTL, 32'h0000_000a, 32'h0000_0008, "rst_fault");
    rdc(A_DAT, 32'hffff_ffff, 32'h0000_2d2d, "dat_keep");
    conclude();
  end
endmodule : tb
bind nvc_top nvc_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .wp_i(wp_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));
`default_nettype wire
